// File: dv/scvbi_regs_asserts.sv
// Port-level checker for the subcarrier, caption and blanking-line register block.
// Assumes one clock domain; bound to every scvbi_regs instance below.
module scvbi_regs_asserts (
    // Clock and reset
    input wire        clk,
    input wire        arst_n,
    // Host pins
    input wire        scl_in,
    input wire        sda_in,
    input wire        sda_out,
    input wire        sda_oe,
    // Video timing and mode
    input wire        pix_en,
    input wire        pal_mode,
    input wire        pedestal_enable_bit,
    input wire        field_odd,
    input wire [9:0]  line_num,
    // Outputs under watch
    input wire [31:0] subcarrier_tuning_word,
    input wire [7:0]  subcarrier_wave_addr,
    input wire [15:0] even_field_caption_bytes,
    input wire [15:0] odd_field_caption_bytes,
    input wire [15:0] caption_word,
    input wire        pedestal_on,
    input wire        teletext_line_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_reset_tuning_byte: assert property (
        $rose(arst_n) |-> subcarrier_tuning_word == 32'h00000016)
        else $error("tuning word not at its reset value after reset");
    a_pedestal_pal_off: assert property (
        pal_mode |=> !pedestal_on)
        else $error("pedestal active in PAL");
    a_teletext_ntsc_off: assert property (
        !pal_mode |=> !teletext_line_en)
        else $error("teletext enabled in NTSC");
    a_pedestal_global_off: assert property (
        !pedestal_enable_bit |=> !pedestal_on)
        else $error("pedestal active while globally disabled");
    a_outside_vbi_lines: assert property (
        (line_num < 10'h00A || line_num > 10'h019) |=> !teletext_line_en &&
        pedestal_on == (!$past(pal_mode) && $past(pedestal_enable_bit)))
        else $error("line control acted outside the blanking lines");
    a_caption_field_sel: assert property (
        1'b1 |=> caption_word == ($past(field_odd) ? $past(odd_field_caption_bytes)
                                                   : $past(even_field_caption_bytes)))
        else $error("caption word not from the current field");
    a_wave_hold_idle: assert property (
        !pix_en |=> $stable(subcarrier_wave_addr))
        else $error("wave address moved without a pixel enable");
    a_tuning_write_time: assert property (
        $changed(subcarrier_tuning_word) |-> !scl_in)
        else $error("tuning word changed outside a host write slot");
    a_ack_after_fall: assert property (
        $rose(sda_oe) |-> !scl_in && sda_out == 1'b0)
        else $error("data line pulled while serial clock high");
endmodule // scvbi_regs_asserts

bind scvbi_regs scvbi_regs_asserts scvbi_regs_asserts_i (
    .clk(clk), .arst_n(arst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .pix_en(pix_en), .pal_mode(pal_mode),
    .pedestal_enable_bit(pedestal_enable_bit), .field_odd(field_odd), .line_num(line_num),
    .subcarrier_tuning_word(subcarrier_tuning_word), .subcarrier_wave_addr(subcarrier_wave_addr),
    .even_field_caption_bytes(even_field_caption_bytes),
    .odd_field_caption_bytes(odd_field_caption_bytes), .caption_word(caption_word),
    .pedestal_on(pedestal_on), .teletext_line_en(teletext_line_en)
);

// File: dv/testbench.sv
// Self-checking bench for scvbi_regs: host port read/write tasks and video-side checks.
// Inputs change at the falling clock edge; the data wire is open drain with a pull-up.
`include "scvbi_defines.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, arst_n, scl, sda_m, pix_en, pal_mode, ped_en, field_odd, ack, lb;
    logic [9:0]  line_num;
    logic [15:0] lm;
    logic [31:0] acc;
    logic [7:0]  rb [0:15];
    wire         sda_out, sda_oe, ped_on, ttx_on;
    wire [31:0]  tword;
    wire [7:0]   wave;
    wire [15:0]  cap_e, cap_o, cap_w;
    int          n_mismatch = 0;
    int          checks = 0;
    // Released wire floats high through the pull-up
    wire         sda_in = sda_m & !(sda_oe & !sda_out);

    scvbi_regs scvbi_regs_i (.clk(clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe(sda_oe), .pix_en(pix_en), .pal_mode(pal_mode),
        .pedestal_enable_bit(ped_en), .field_odd(field_odd), .line_num(line_num),
        .subcarrier_tuning_word(tword), .subcarrier_wave_addr(wave),
        .even_field_caption_bytes(cap_e), .odd_field_caption_bytes(cap_o),
        .caption_word(cap_w), .pedestal_on(ped_on), .teletext_line_en(ttx_on));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Serial clock runs at 1/16 of clk so every edge is seen by several samples
    task automatic hbit(input logic b, output logic r);
        sda_m = b;
        tick(4);
        scl = 1'b1;
        tick(4);
        r = sda_in;
        tick(4);
        scl = 1'b0;
        tick(4);
    endtask

    task automatic hbyte(input logic [7:0] d, input logic mack, output logic [7:0] r,
                         output logic a);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            hbit(d[i], b);
            r[i] = b;
        end
        hbit(mack, b);
        a = !b;
    endtask

    task automatic hstart;
        sda_m = 1'b1;
        scl = 1'b1;
        tick(4);
        sda_m = 1'b0;
        tick(4);
        scl = 1'b0;
        tick(4);
    endtask

    task automatic hstop;
        sda_m = 1'b0;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_m = 1'b1;
        tick(4);
    endtask

    // Bytes go out lowest first from the low end of d
    task automatic wr(input logic [7:0] sub, input int n, input logic [63:0] d);
        logic [7:0] r;
        hstart();
        hbyte({`SCVBI_DEV_ADDR, 1'b0}, 1'b1, r, ack);
        check("address ack", ack, 1);
        hbyte(sub, 1'b1, r, ack);
        for (int i = 0; i < n; i++) hbyte(d[8*i +: 8], 1'b1, r, ack);
        hstop();
    endtask

    task automatic rd(input logic [7:0] sub, input int n);
        logic [7:0] r;
        hstart();
        hbyte({`SCVBI_DEV_ADDR, 1'b0}, 1'b1, r, ack);
        hbyte(sub, 1'b1, r, ack);
        hstart();
        hbyte({`SCVBI_DEV_ADDR, 1'b1}, 1'b1, r, ack);
        for (int i = 0; i < n; i++) hbyte(8'hFF, i == n - 1, rb[i], ack);
        hstop();
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        give_verdict();
    end

    initial begin
        {arst_n, pix_en, pal_mode, field_odd} = 4'h0;
        {scl, sda_m, ped_en} = 3'h7;
        line_num = 10'h000;
        repeat (16) @(posedge clk);
        @(negedge clk) arst_n = 1'b1;
        tick(4);
        check("tuning word reset", tword, 32'h00000016);
        rd(`SCVBI_SUB_FREQ0, 13);
        check("freq byte0 reset", rb[0], 8'h16);
        for (int i = 1; i < 13; i++) check("byte reset", rb[i], 8'h00);
        wr(`SCVBI_SUB_FREQ0, 5, 64'h0021F07C1F);
        check("tuning word", tword, 32'h21F07C1F);
        check("tuning formula", tword, 32'($rtoi(227.5 / 1716.0 * 4294967296.0 + 0.5)));
        rd(`SCVBI_SUB_FREQ0, 5);
        for (int i = 0; i < 5; i++) begin
            check("readback", rb[i], 40'h0021F07C1F >> (8 * i) & 8'hFF);
        end
        wr(`SCVBI_SUB_CAP_EVEN_L, 4, 64'h3CC355AA);
        check("even caption", cap_e, 16'h55AA);
        check("odd caption", cap_o, 16'h3CC3);
        field_odd = 1'b1;
        tick(2);
        check("odd caption word", cap_w, 16'h3CC3);
        field_odd = 1'b0;
        tick(2);
        check("even caption word", cap_w, 16'h55AA);
        wr(8'h20, 1, 64'h5A);
        rd(8'h20, 1);
        check("unmapped read", rb[0], 8'h00);
        hstart();
        hbyte({7'h2B, 1'b0}, 1'b1, rb[0], ack);
        check("foreign address ack", ack, 0);
        hstop();
        wr(`SCVBI_SUB_VBI0, 4, 64'h01400281);
        // Mode 0: NTSC without pedestal, 1: NTSC with pedestal, 2: PAL with the bit still set
        for (int m = 0; m < 3; m++) for (int f = 0; f < 2; f++)
            for (int ln = 8; ln < 28; ln++) begin
            pal_mode = (m == 2);
            ped_en = (m != 0);
            field_odd = f[0];
            line_num = ln[9:0];
            lm = f ? 16'h0281 : 16'h0140;
            lb = (ln >= 10 && ln <= 25) ? lm[ln - 10] : 1'b0;
            tick(2);
            check("teletext line", ttx_on, pal_mode && lb);
            check("pedestal line", ped_on, ped_en && !pal_mode && !lb);
        end
        acc = 32'h00000000;
        for (int k = 0; k < 16; k++) begin
            if (k == 8) wr(`SCVBI_SUB_PHASE, 1, 64'h40);
            pix_en = 1'b1;
            tick(1);
            pix_en = 1'b0;
            tick(1);
            // The wave address wraps at eight bits, so the expectation must too
            check("wave addr", wave, 8'(acc[31:24] + ((k >= 8) ? 8'h40 : 8'h00)));
            acc = acc + 32'h21F07C1F;
        end
        give_verdict();
    end
endmodule // testbench

// File: shared/scvbi_defines.vh
// Constants for the subcarrier, caption and blanking-line register block.
// Assumes one system clock and a two-wire serial host port in front of the registers.
//
// What this block does
// (R1) Software writes round(2^32 * line subcarrier cycles / line 27 MHz clocks) as tuning word.
// (R2) Four consecutive byte registers hold the 32-bit tuning word, lowest byte first.
// (R3) The low tuning byte resets to 16 hex and software should rewrite it as 1F hex for NTSC.
// (R4) For NTSC software programs 227.5 over 1716 as bytes 1F, 7C, F0, 21 from low to high.
// (R5) A byte-wide phase register shifts the subcarrier phase by 1.41 degrees per unit.
// (R6) Software leaves the phase register at zero for normal operation.
// (R7) Two byte registers hold the even-field caption data and feed even-field caption insertion.
// (R8) Two byte registers hold the odd-field caption data and feed odd-field caption insertion.
// (R9) Four byte registers hold one bit per blanking line per field, meaning set by the standard.
// (R10) In NTSC a set line bit removes the pedestal on that line and a clear bit keeps it.
// (R11) In PAL a set line bit enables teletext on that line and a clear bit keeps it off.
// (R12) In the first line register for fields 1 and 3, bits 7 to 0 map to lines 17 to 10.
// (R13) The tuning word is accumulated per pixel clock; the phase byte offsets the top byte.
// (R14) The per-line pedestal control acts only in NTSC and has no meaning in PAL.

`ifndef SCVBI_DEFINES_VH
`define SCVBI_DEFINES_VH

// Register subaddresses
`define SCVBI_SUB_FREQ0      8'h09
`define SCVBI_SUB_FREQ1      8'h0A
`define SCVBI_SUB_FREQ2      8'h0B
`define SCVBI_SUB_FREQ3      8'h0C
`define SCVBI_SUB_PHASE      8'h0D
`define SCVBI_SUB_CAP_EVEN_L 8'h0E
`define SCVBI_SUB_CAP_EVEN_H 8'h0F
`define SCVBI_SUB_CAP_ODD_L  8'h10
`define SCVBI_SUB_CAP_ODD_H  8'h11
`define SCVBI_SUB_VBI0       8'h12
`define SCVBI_SUB_VBI1       8'h13
`define SCVBI_SUB_VBI2       8'h14
`define SCVBI_SUB_VBI3       8'h15

// Reset values
`define SCVBI_FREQ0_RST      8'h16
`define SCVBI_BYTE_RST       8'h00

// Blanking-line map: mask bit i stands for line FIRST_LINE + i
`define SCVBI_VBI_FIRST_LINE 10'h00A
`define SCVBI_VBI_LINES      16

// Serial host port
`define SCVBI_DEV_ADDR       7'h2A
`define SCVBI_RW_BIT         0

`endif

// File: src/scvbi_regs.v
// Subcarrier tuning, caption data and blanking-line control registers with their logic.
// Assumes a pixel-rate enable, line number and field flag from the timing generator,
// and the standard select and pedestal bit from the mode registers outside this block.

`include "scvbi_defines.vh"

module scvbi_regs (
    // Clock and reset
    input  wire        clk,
    input  wire        arst_n,
    // Two-wire host pins
    input  wire        scl_in,
    input  wire        sda_in,
    output wire        sda_out,
    output wire        sda_oe,
    // Video timing and mode
    input  wire        pix_en,
    input  wire        pal_mode,
    input  wire        pedestal_enable_bit,
    input  wire        field_odd,
    input  wire [9:0]  line_num,
    // Subcarrier
    output wire [31:0] subcarrier_tuning_word,
    output reg  [7:0]  subcarrier_wave_addr,
    // Captions
    output wire [15:0] even_field_caption_bytes,
    output wire [15:0] odd_field_caption_bytes,
    output reg  [15:0] caption_word,
    // Per-line controls
    output reg         pedestal_on,
    output reg         teletext_line_en
);
    wire [7:0] register_subaddress;
    wire       wr_stb;
    wire [7:0] wr_data;
    reg  [7:0] rd_data;

    reg  [7:0] subcarrier_freq_byte0;
    reg  [7:0] subcarrier_freq_byte1;
    reg  [7:0] subcarrier_freq_byte2;
    reg  [7:0] subcarrier_freq_byte3;
    reg  [7:0] subcarrier_phase_offset;
    reg  [7:0] caption_even_low;
    reg  [7:0] caption_even_high;
    reg  [7:0] caption_odd_low;
    reg  [7:0] caption_odd_high;
    reg  [7:0] vbi_line_ctrl_0;
    reg  [7:0] vbi_line_ctrl_1;
    reg  [7:0] vbi_line_ctrl_2;
    reg  [7:0] vbi_line_ctrl_3;
    reg  [31:0] phase_acc;

    scvbi_serial_port u_port (
        .clk                 (clk),
        .arst_n              (arst_n),
        .scl_in              (scl_in),
        .sda_in              (sda_in),
        .sda_out             (sda_out),
        .sda_oe              (sda_oe),
        .register_subaddress (register_subaddress),
        .wr_stb              (wr_stb),
        .wr_data             (wr_data),
        .rd_data             (rd_data)
    );

    // Register writes; subaddresses outside the block are ignored
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            subcarrier_freq_byte0   <= `SCVBI_FREQ0_RST; // [R3]
            subcarrier_freq_byte1   <= `SCVBI_BYTE_RST;
            subcarrier_freq_byte2   <= `SCVBI_BYTE_RST;
            subcarrier_freq_byte3   <= `SCVBI_BYTE_RST;
            subcarrier_phase_offset <= `SCVBI_BYTE_RST;
            caption_even_low        <= `SCVBI_BYTE_RST;
            caption_even_high       <= `SCVBI_BYTE_RST;
            caption_odd_low         <= `SCVBI_BYTE_RST;
            caption_odd_high        <= `SCVBI_BYTE_RST;
            vbi_line_ctrl_0         <= `SCVBI_BYTE_RST;
            vbi_line_ctrl_1         <= `SCVBI_BYTE_RST;
            vbi_line_ctrl_2         <= `SCVBI_BYTE_RST;
            vbi_line_ctrl_3         <= `SCVBI_BYTE_RST;
        end else if (wr_stb) begin
            case (register_subaddress)
                `SCVBI_SUB_FREQ0:      subcarrier_freq_byte0   <= wr_data; // [R2]
                `SCVBI_SUB_FREQ1:      subcarrier_freq_byte1   <= wr_data; // [R2]
                `SCVBI_SUB_FREQ2:      subcarrier_freq_byte2   <= wr_data; // [R2]
                `SCVBI_SUB_FREQ3:      subcarrier_freq_byte3   <= wr_data; // [R2]
                `SCVBI_SUB_PHASE:      subcarrier_phase_offset <= wr_data; // [R5]
                `SCVBI_SUB_CAP_EVEN_L: caption_even_low        <= wr_data; // [R7]
                `SCVBI_SUB_CAP_EVEN_H: caption_even_high       <= wr_data; // [R7]
                `SCVBI_SUB_CAP_ODD_L:  caption_odd_low         <= wr_data; // [R8]
                `SCVBI_SUB_CAP_ODD_H:  caption_odd_high        <= wr_data; // [R8]
                `SCVBI_SUB_VBI0:       vbi_line_ctrl_0         <= wr_data; // [R9]
                `SCVBI_SUB_VBI1:       vbi_line_ctrl_1         <= wr_data; // [R9]
                `SCVBI_SUB_VBI2:       vbi_line_ctrl_2         <= wr_data; // [R9]
                `SCVBI_SUB_VBI3:       vbi_line_ctrl_3         <= wr_data; // [R9]
                default: begin
                end
            endcase
        end
    end

    // Readback; unmapped subaddresses read as zero
    always @* begin
        case (register_subaddress)
            `SCVBI_SUB_FREQ0:      rd_data = subcarrier_freq_byte0;
            `SCVBI_SUB_FREQ1:      rd_data = subcarrier_freq_byte1;
            `SCVBI_SUB_FREQ2:      rd_data = subcarrier_freq_byte2;
            `SCVBI_SUB_FREQ3:      rd_data = subcarrier_freq_byte3;
            `SCVBI_SUB_PHASE:      rd_data = subcarrier_phase_offset;
            `SCVBI_SUB_CAP_EVEN_L: rd_data = caption_even_low;
            `SCVBI_SUB_CAP_EVEN_H: rd_data = caption_even_high;
            `SCVBI_SUB_CAP_ODD_L:  rd_data = caption_odd_low;
            `SCVBI_SUB_CAP_ODD_H:  rd_data = caption_odd_high;
            `SCVBI_SUB_VBI0:       rd_data = vbi_line_ctrl_0;
            `SCVBI_SUB_VBI1:       rd_data = vbi_line_ctrl_1;
            `SCVBI_SUB_VBI2:       rd_data = vbi_line_ctrl_2;
            `SCVBI_SUB_VBI3:       rd_data = vbi_line_ctrl_3;
            default:               rd_data = 8'h00;
        endcase
    end

    // Low byte at the lowest subaddress
    assign subcarrier_tuning_word = {subcarrier_freq_byte3, subcarrier_freq_byte2,
                                     subcarrier_freq_byte1, subcarrier_freq_byte0}; // [R2]

    // Direct digital synthesis of the subcarrier; the phase byte is a 360/256 degree step
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_acc            <= 32'h0000_0000;
            subcarrier_wave_addr <= 8'h00;
        end else if (pix_en) begin
            phase_acc            <= phase_acc + subcarrier_tuning_word; // [R13]
            subcarrier_wave_addr <= phase_acc[31:24] + subcarrier_phase_offset; // [R13] [R5]
        end
    end

    assign even_field_caption_bytes = {caption_even_high, caption_even_low}; // [R7]
    assign odd_field_caption_bytes  = {caption_odd_high, caption_odd_low};   // [R8]

    // Odd fields use registers 0 and 1, even fields 2 and 3; bit i is line 10 + i
    wire [15:0] odd_line_mask  = {vbi_line_ctrl_1, vbi_line_ctrl_0};  // [R12]
    wire [15:0] even_line_mask = {vbi_line_ctrl_3, vbi_line_ctrl_2};
    wire [15:0] odd_pedestal_line_mask  = odd_line_mask;
    wire [15:0] even_pedestal_line_mask = even_line_mask;
    wire [15:0] odd_teletext_line_mask  = odd_line_mask;
    wire [15:0] even_teletext_line_mask = even_line_mask;

    wire [15:0] line_hit;
    genvar gi;
    generate
        for (gi = 0; gi < `SCVBI_VBI_LINES; gi = gi + 1) begin : g_line
            localparam [31:0] LINE_OFS = gi;
            assign line_hit[gi] = (line_num == (`SCVBI_VBI_FIRST_LINE + LINE_OFS[9:0])); // [R12]
        end
    endgenerate

    wire ped_bit = |(line_hit & (field_odd ? odd_pedestal_line_mask
                                           : even_pedestal_line_mask)); // [R9]
    wire ttx_bit = |(line_hit & (field_odd ? odd_teletext_line_mask
                                           : even_teletext_line_mask)); // [R9]

    // Registered video-side controls, valid one clock after line or field changes
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pedestal_on      <= 1'b0;
            teletext_line_en <= 1'b0;
            caption_word     <= 16'h0000;
        end else begin
            // Pedestal only exists in NTSC; the mask is ignored in PAL
            pedestal_on      <= ~pal_mode & pedestal_enable_bit & ~ped_bit; // [R10] [R14]
            teletext_line_en <= pal_mode & ttx_bit; // [R11]
            caption_word     <= field_odd ? odd_field_caption_bytes
                                          : even_field_caption_bytes; // [R7] [R8]
        end
    end
endmodule // scvbi_regs

// File: src/scvbi_serial_port.v
// Two-wire serial host port slave: subaddress pointer, auto-increment, byte writes and reads.
// Assumes scl and sda inputs are already synchronous to clk and far slower than clk.

`include "scvbi_defines.vh"

module scvbi_serial_port (
    // Clock and reset
    input  wire       clk,
    input  wire       arst_n,
    // Two-wire pins
    input  wire       scl_in,
    input  wire       sda_in,
    output wire       sda_out,
    output reg        sda_oe,
    // Register side
    output reg  [7:0] register_subaddress,
    output reg        wr_stb,
    output reg  [7:0] wr_data,
    input  wire [7:0] rd_data
);
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_ADDR  = 3'h1;
    localparam [2:0] ST_ACK_A = 3'h2;
    localparam [2:0] ST_RECV  = 3'h3;
    localparam [2:0] ST_ACK_W = 3'h4;
    localparam [2:0] ST_RDATA = 3'h5;
    localparam [2:0] ST_RACK  = 3'h6;

    reg  [2:0] state;
    reg  [3:0] bitcnt;
    reg  [7:0] shreg;
    reg        rw;
    reg        got_sub;
    reg        scl_q;
    reg        sda_q;

    wire scl_rise = scl_in & ~scl_q;
    wire scl_fall = ~scl_in & scl_q;
    wire start_c  = scl_in & scl_q & sda_q & ~sda_in;
    wire stop_c   = scl_in & scl_q & ~sda_q & sda_in;

    // Open-drain: only ever pulls low
    assign sda_out = 1'b0;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state               <= ST_IDLE;
            bitcnt              <= 4'h0;
            shreg               <= 8'h00;
            rw                  <= 1'b0;
            got_sub             <= 1'b0;
            scl_q               <= 1'b1;
            sda_q               <= 1'b1;
            sda_oe              <= 1'b0;
            register_subaddress <= 8'h00;
            wr_stb              <= 1'b0;
            wr_data             <= 8'h00;
        end else begin
            scl_q  <= scl_in;
            sda_q  <= sda_in;
            wr_stb <= 1'b0;
            if (start_c) begin
                state  <= ST_ADDR;
                bitcnt <= 4'h0;
                sda_oe <= 1'b0;
            end else if (stop_c) begin
                state  <= ST_IDLE;
                sda_oe <= 1'b0;
            end else begin
                case (state)
                    ST_ADDR, ST_RECV: begin
                        if (scl_rise && bitcnt != 4'h8) begin
                            shreg  <= {shreg[6:0], sda_in};
                            bitcnt <= bitcnt + 4'h1;
                        end else if (scl_fall && bitcnt == 4'h8) begin
                            bitcnt <= 4'h0;
                            if (state == ST_ADDR) begin
                                if (shreg[7:1] == `SCVBI_DEV_ADDR) begin
                                    sda_oe <= 1'b1;
                                    rw     <= shreg[`SCVBI_RW_BIT];
                                    state  <= ST_ACK_A;
                                end else begin
                                    state <= ST_IDLE;
                                end
                            end else begin
                                sda_oe <= 1'b1;
                                state  <= ST_ACK_W;
                                if (!got_sub) begin
                                    register_subaddress <= shreg;
                                    got_sub             <= 1'b1;
                                end else begin
                                    wr_stb  <= 1'b1;
                                    wr_data <= shreg;
                                end
                            end
                        end
                    end
                    ST_ACK_A: begin
                        if (scl_fall) begin
                            if (rw) begin
                                shreg  <= rd_data;
                                sda_oe <= ~rd_data[7];
                                state  <= ST_RDATA;
                            end else begin
                                sda_oe  <= 1'b0;
                                got_sub <= 1'b0;
                                state   <= ST_RECV;
                            end
                        end
                    end
                    ST_ACK_W: begin
                        // Step the pointer after the strobe so the write used the old one
                        if (wr_stb) begin
                            register_subaddress <= register_subaddress + 8'h01;
                        end
                        if (scl_fall) begin
                            sda_oe <= 1'b0;
                            state  <= ST_RECV;
                        end
                    end
                    ST_RDATA: begin
                        if (scl_fall) begin
                            if (bitcnt == 4'h7) begin
                                sda_oe              <= 1'b0;
                                register_subaddress <= register_subaddress + 8'h01;
                                state               <= ST_RACK;
                            end else begin
                                bitcnt <= bitcnt + 4'h1;
                                sda_oe <= ~shreg[6];
                                shreg  <= {shreg[6:0], 1'b0};
                            end
                        end
                    end
                    ST_RACK: begin
                        // A high ninth bit from the master ends the read
                        if (scl_rise && sda_in) begin
                            state <= ST_IDLE;
                        end else if (scl_fall) begin
                            bitcnt <= 4'h0;
                            shreg  <= rd_data;
                            sda_oe <= ~rd_data[7];
                            state  <= ST_RDATA;
                        end
                    end
                    default: begin
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule // scvbi_serial_port
